// ===== core/scrp_consts.svh
// constants for the serial control register port: frame layout, addresses, defaults
`ifndef SCRP_CONSTS_SVH
`define SCRP_CONSTS_SVH

// frame layout, counted in serial clock rising edges
`define SCRP_FRAME_BITS 5'd24
`define SCRP_CMD_BITS 5'd8
`define SCRP_LAST_ADDR_CNT 5'd7
`define SCRP_LAST_DATA_CNT 5'd23
`define SCRP_FIRST_DATA_CNT 5'd9

// register addresses
`define SCRP_ADDR_MAIN_CONFIGURATION 4'h0
`define SCRP_ADDR_COMMON_MODE_ADJUST 4'h1
`define SCRP_ADDR_OFFSET_ADJUST_FIRST 4'h2
`define SCRP_ADDR_FULL_SCALE_ADJUST_FIRST 4'h3
`define SCRP_ADDR_OFFSET_ADJUST_SECOND 4'ha
`define SCRP_ADDR_FULL_SCALE_ADJUST_SECOND 4'hb
`define SCRP_ADDR_SAMPLE_PHASE_ADJUST 4'hc
`define SCRP_ADDR_CLOCK_FILTER_PHASE_ADJUST 4'hd

// one bit per address that holds a real register
`define SCRP_IMPL_MASK 16'h3c0f

// reset value of every register
`define SCRP_REG_DEFAULT 16'h0000

// main configuration field positions
`define SCRP_BIT_TWOS_COMPLEMENT 4
`define SCRP_BIT_DUAL_EDGE 7
`define SCRP_BIT_TEST_PATTERN 12
`define SCRP_BIT_OUTPUT_SWING 13
`define SCRP_BIT_CLOCK_PHASE 14

// synchroniser reset: mode pin high, select high, clock low, data low
`define SCRP_SYNC_RESET 4'hc

`endif

// ===== core/scrp_pkg.sv
// types shared by the serial control register port modules
package scrp_pkg;
    // frame sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD} scrp_state_e;
    // register address and word
    typedef logic [3:0] scrp_addr_t;
    typedef logic [15:0] scrp_word_t;
    // rising edge count inside a frame
    typedef logic [4:0] scrp_count_t;
endpackage

// ===== core/scrp_reg_if.sv
// register file access signals between the frame logic and the register memory
`timescale 1ns/100ps
interface scrp_reg_if;
    import scrp_pkg::*;
    logic we; // write strobe, one cycle
    logic re; // read strobe, one cycle
    logic clear; // hold all registers at default
    scrp_addr_t waddr; // write address
    scrp_addr_t raddr; // read address
    scrp_word_t wdata; // write data
    scrp_word_t rdata; // registered read data
    modport ctrl (output we, output re, output clear, output waddr, output raddr,
        output wdata, input rdata);
    modport mem (input we, input re, input clear, input waddr, input raddr,
        input wdata, output rdata);
endinterface

// ===== core/scrp_reg_mem.sv
// sixteen-word register memory with registered read data and default clear
`timescale 1ns/100ps
`include "scrp_consts.svh"
module scrp_reg_mem #(
    parameter int DEPTH = 16,
    parameter logic [15:0] IMPL_MASK = `SCRP_IMPL_MASK
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // access port
    scrp_reg_if.mem bus
);
    import scrp_pkg::*;

    scrp_word_t regs [DEPTH]; // register storage

    // storage: cleared to defaults while held, written only where a register exists;
    // nothing here looks at power-down, so contents survive it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                regs[i] <= `SCRP_REG_DEFAULT;
            end
        end else if (bus.clear) begin
            // mode pin high keeps everything at default
            for (int i = 0; i < DEPTH; i++) begin
                regs[i] <= `SCRP_REG_DEFAULT;
            end
        end else if (bus.we && IMPL_MASK[bus.waddr]) begin
            regs[bus.waddr] <= bus.wdata;
        end
    end

    // read data register; missing registers read as zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus.rdata <= 16'h0000;
        end else if (bus.re) begin
            bus.rdata <= IMPL_MASK[bus.raddr] ? regs[bus.raddr] : 16'h0000;
        end
    end

    // unmapped reads come back empty
    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.re && !IMPL_MASK[bus.raddr] |=> bus.rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");
    // a write to a real register lands in storage on the next edge
    write_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.we && IMPL_MASK[bus.waddr] && !bus.clear
        |=> regs[$past(bus.waddr)] == $past(bus.wdata))
        else $error("register did not keep written data");
endmodule

// ===== core/scrp_serial_port.sv
// serial control register port: 24-bit frame decode, register access, read data output
`timescale 1ns/100ps
`include "scrp_consts.svh"
module scrp_serial_port (
    // system clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // mode pin, low selects extended control mode
    input wire logic EXTENDED_MODE_SELECT_N_I,
    // serial link pins from the host
    input wire logic SERIAL_SELECT_N_I,
    input wire logic SERIAL_CLK_I,
    input wire logic SERIAL_IN_I,
    // serial data out, with its enable
    output logic SERIAL_OUT_O,
    output logic SERIAL_OUT_OE_O,
    // mode status
    output logic EXTENDED_CONTROL_MODE_O,
    // main configuration controls to the converter
    output logic DUAL_EDGE_SELECT_O,
    output logic TEST_PATTERN_SELECT_O,
    output logic OUTPUT_CLOCK_PHASE_SELECT_O,
    output logic OUTPUT_SWING_SELECT_O,
    output logic TWOS_COMPLEMENT_SELECT_O
);
    import scrp_pkg::*;

    logic [3:0] sync_a; // first synchroniser stage
    logic [3:0] sync_b; // second synchroniser stage
    logic sclk_d; // delayed synced serial clock
    logic sel_n_d; // delayed synced select
    logic mode_n_s; // synced mode pin
    logic sel_n_s; // synced select
    logic sclk_s; // synced serial clock
    logic sin_s; // synced serial data
    logic rise; // serial clock rising edge seen
    logic fall; // serial clock falling edge seen
    logic start; // select assertion edge
    logic abort; // select high or mode off
    scrp_state_e state; // frame sequencer state
    scrp_count_t cnt; // rising edges so far in this frame
    logic [22:0] frame; // bits received, newest in bit 0
    logic rd_flag; // current access is a read
    logic [14:0] out_sr; // remaining read data bits
    logic out_bit; // serial output data flop
    logic out_oe; // serial output enable flop
    scrp_word_t cfg; // shadow of main configuration
    logic extended_control_mode; // extended control mode flop

    // register memory access
    scrp_reg_if regs_bus ();

    // pins cross into the system clock through two flops
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            sync_a <= `SCRP_SYNC_RESET;
            sync_b <= `SCRP_SYNC_RESET;
        end else begin
            sync_a <= {EXTENDED_MODE_SELECT_N_I, SERIAL_SELECT_N_I, SERIAL_CLK_I, SERIAL_IN_I};
            sync_b <= sync_a;
        end
    end

    // synced pin names
    assign mode_n_s = sync_b[3];
    assign sel_n_s = sync_b[2];
    assign sclk_s = sync_b[1];
    assign sin_s = sync_b[0];

    // edge detection delays
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_d <= 1'b0;
            sel_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            sel_n_d <= sel_n_s;
        end
    end

    // edges of the serial clock and of select
    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign start = sel_n_d & ~sel_n_s & ~mode_n_s;
    assign abort = sel_n_s | mode_n_s;

    // mode flag, low pin means extended control mode
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            extended_control_mode <= 1'b0;
        end else begin
            extended_control_mode <= ~mode_n_s;
        end
    end

    // frame sequencer; waits on edges only, so a stopped clock just pauses it
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
        end else if (abort) begin
            // release before the 24th edge drops the access unfinished
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // a held-low select without a new fall never restarts
                    if (start) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (rise && cnt == `SCRP_LAST_DATA_CNT) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // further edges are ignored until select goes high
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // rising edge counter and input shifter
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cnt <= 5'h00;
            frame <= 23'h000000;
        end else if (start) begin
            cnt <= 5'h00;
        end else if (state == ST_SHIFT && rise) begin
            cnt <= 5'(cnt + 5'h01);
            frame <= {frame[21:0], sin_s};
        end
    end

    // direction flag from the first bit
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rd_flag <= 1'b0;
        end else if (start) begin
            rd_flag <= 1'b0;
        end else if (state == ST_SHIFT && rise && cnt == 5'h00) begin
            rd_flag <= sin_s;
        end
    end

    // read at the 8th edge: address sits in bits four to seven
    assign regs_bus.re = (state == ST_SHIFT) && rise && cnt == `SCRP_LAST_ADDR_CNT
        && rd_flag && !abort;
    assign regs_bus.raddr = frame[3:0];
    // write at the 24th edge with bit eight skipped; only a full frame writes
    assign regs_bus.we = (state == ST_SHIFT) && rise && cnt == `SCRP_LAST_DATA_CNT
        && !rd_flag && !abort;
    assign regs_bus.waddr = frame[19:16];
    assign regs_bus.wdata = {frame[14:0], sin_s};
    // mode pin high holds the register file at default
    assign regs_bus.clear = mode_n_s;

    // register memory
    scrp_reg_mem #(
        .DEPTH(16),
        .IMPL_MASK(`SCRP_IMPL_MASK)
    ) u_mem (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .bus(regs_bus)
    );

    // read data driver, turns on and shifts on falling edges, turns off on abort or idle
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            out_oe <= 1'b0;
            out_bit <= 1'b0;
            out_sr <= 15'h0000;
        end else if (abort || state == ST_IDLE) begin
            out_oe <= 1'b0;
        end else if (fall && rd_flag) begin
            if (cnt == `SCRP_CMD_BITS) begin
                // command complete: turn the line around, MSB first
                out_oe <= 1'b1;
                out_bit <= regs_bus.rdata[15];
                out_sr <= regs_bus.rdata[14:0];
            end else if (cnt >= `SCRP_FIRST_DATA_CNT && cnt <= `SCRP_LAST_DATA_CNT) begin
                out_bit <= out_sr[14];
                out_sr <= {out_sr[13:0], 1'b0};
            end
            // past the 24th edge the last bit simply stays
        end
    end

    // converter-side copy of the main configuration; written only from the
    // synchronised frame logic, so settings change cleanly in this domain
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cfg <= `SCRP_REG_DEFAULT;
        end else if (mode_n_s) begin
            cfg <= `SCRP_REG_DEFAULT;
        end else if (regs_bus.we && regs_bus.waddr == `SCRP_ADDR_MAIN_CONFIGURATION) begin
            cfg <= regs_bus.wdata;
        end
    end

    // outputs
    assign SERIAL_OUT_O = out_bit;
    assign SERIAL_OUT_OE_O = out_oe;
    assign EXTENDED_CONTROL_MODE_O = extended_control_mode;
    assign DUAL_EDGE_SELECT_O = cfg[`SCRP_BIT_DUAL_EDGE];
    assign TEST_PATTERN_SELECT_O = cfg[`SCRP_BIT_TEST_PATTERN];
    assign OUTPUT_CLOCK_PHASE_SELECT_O = cfg[`SCRP_BIT_CLOCK_PHASE];
    assign OUTPUT_SWING_SELECT_O = cfg[`SCRP_BIT_OUTPUT_SWING];
    assign TWOS_COMPLEMENT_SELECT_O = cfg[`SCRP_BIT_TWOS_COMPLEMENT];

    // output released once select is high
    oe_release_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        sel_n_s |=> !out_oe)
        else $error("serial output driven with select released");
    // output driven only on a read past the command
    oe_read_only_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        out_oe |-> rd_flag && cnt >= `SCRP_CMD_BITS)
        else $error("serial output driven outside read data phase");
    // writes only happen at the 24th edge of a write
    write_timing_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        regs_bus.we |-> cnt == `SCRP_LAST_DATA_CNT && !rd_flag && !sel_n_s)
        else $error("register write outside 24th edge of write frame");
    // reads are issued only for a read flag
    read_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        regs_bus.re |-> frame[6] && cnt == `SCRP_LAST_ADDR_CNT)
        else $error("register read without read flag");
    // first data bit is the word's MSB
    msb_first_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        fall && rd_flag && cnt == `SCRP_CMD_BITS && !abort && state != ST_IDLE
        |=> out_oe && out_bit == $past(regs_bus.rdata[15]))
        else $error("read data did not start with MSB");
    // last bit held past the frame
    last_bit_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        state == ST_HOLD && !abort ##1 state == ST_HOLD |-> $stable(out_bit))
        else $error("last data bit not held");
    // frame never exceeds 24 edges
    frame_length_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        cnt <= `SCRP_FRAME_BITS)
        else $error("frame counter beyond 24");
    // mode pin high forces default configuration
    hold_default_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        mode_n_s |=> cfg == `SCRP_REG_DEFAULT && !extended_control_mode)
        else $error("configuration not held at default");
    // edge count advances only on rising clock
    sample_rise_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        cnt != $past(cnt) && cnt != 5'h00 |-> $past(rise))
        else $error("bit counted without rising edge");
    // configuration write reaches outputs next cycle
    cfg_update_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        regs_bus.we && regs_bus.waddr == 4'h0 |=> TWOS_COMPLEMENT_SELECT_O
        == $past(regs_bus.wdata[4]) && OUTPUT_SWING_SELECT_O == $past(regs_bus.wdata[13]))
        else $error("configuration outputs not updated by write");
    // mode pin low turns extended control mode on
    ext_mode_on_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !mode_n_s |=> extended_control_mode)
        else $error("extended control mode not entered");
    // select or mode release drops any access in flight
    abandon_access_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        abort |=> state == ST_IDLE && !regs_bus.we)
        else $error("access kept running after select release");
    // select fall restarts the frame from its first bit
    frame_start_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        start |=> state == ST_SHIFT && cnt == 5'h00 && !rd_flag)
        else $error("new access did not start at its first bit");

    // main scenarios
    read_done_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
        state == ST_HOLD && rd_flag && out_oe);
    write_done_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
        regs_bus.we && regs_bus.waddr == 4'h0);
    abort_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
        state == ST_SHIFT && sel_n_s && cnt > 5'h08);
    long_read_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
        state == ST_HOLD && rd_flag && fall);
endmodule

// ===== test/scrp_host_model.sv
// host-side serial master model that frames register accesses on the port
`timescale 1ns/100ps
module scrp_host_model (
    // system clock used to pace the link clock
    input wire logic clk_i,
    // shared data wire and the device's drive enable
    input wire logic sdio_i,
    input wire logic oe_dev_i,
    // link pins driven by the host
    output logic sel_n_o,
    output logic sclk_o,
    output logic sd_o,
    output logic sd_oe_o
);
    logic [15:0] rd; // data gathered during a read
    logic early_oe; // device drove the wire during command bits or a write
    logic tail_bad; // wire changed after the last data bit

    // idle link: deselected, clock parked low
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        sd_o = 1'b0;
        sd_oe_o = 1'b1;
        rd = 16'h0000;
        early_oe = 1'b0;
        tail_bad = 1'b0;
    end

    // half of the 400 ns link clock period
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask

    // one access of nclk rising edges; stall parks the clock low mid-frame
    task automatic frame(input logic rw, input logic [3:0] addr,
        input logic [15:0] wd, input int nclk, input int stall);
        logic [23:0] v;
        v = {rw, 2'b10, addr, 1'b1, wd};
        early_oe = 1'b0;
        tail_bad = 1'b0;
        rd = 16'h0000;
        sel_n_o = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            // data changes while the clock is low
            if (i < 24) begin
                sd_o = v[23 - i];
            end
            sd_oe_o = !(rw && i >= 8);
            if (i == 12) begin
                repeat (stall) half();
            end
            half();
            sclk_o = 1'b1;
            // sample the wire at the rising edge
            if ((i < 8 || !rw) && oe_dev_i === 1'b1) begin
                early_oe = 1'b1;
            end
            if (i >= 8 && i < 24) begin
                rd[23 - i] = sdio_i;
            end
            if (i >= 24 && sdio_i !== rd[0]) begin
                tail_bad = 1'b1;
            end
            half();
            sclk_o = 1'b0;
        end
        half();
        sel_n_o = 1'b1;
        sd_oe_o = 1'b1;
        half();
        half();
    endtask
endmodule

// ===== test/tb_scrp_serial_port.sv
// self-checking bench for the serial control register port
`timescale 1ns/100ps
`include "scrp_consts.svh"
module tb_scrp_serial_port;
    logic clk_sys = 1'b0; // system clock
    logic rst = 1'b1; // async reset
    logic mode_n = 1'b1; // mode pin
    logic sel_n, sclk, h_d, h_oe; // host pins
    logic s_out, s_oe, ext_mode; // device pins
    logic phase, swing, tpat, dual, twos; // config outputs
    logic sdio; // resolved shared data wire
    logic sdio_last = 1'b0; // last wire level, for the undriven case
    int err_total = 0;
    int samples_checked = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    // shared wire: device drive wins over host drive, else a toggling level
    assign sdio = s_oe ? s_out : (h_oe ? h_d : ~sdio_last);
    always @(posedge clk_sys) sdio_last <= sdio;

    scrp_host_model host (.clk_i(clk_sys), .sdio_i(sdio), .oe_dev_i(s_oe),
        .sel_n_o(sel_n), .sclk_o(sclk), .sd_o(h_d), .sd_oe_o(h_oe));

    scrp_serial_port DUT (.CLK_SYS_I(clk_sys), .RST_I(rst),
        .EXTENDED_MODE_SELECT_N_I(mode_n), .SERIAL_SELECT_N_I(sel_n),
        .SERIAL_CLK_I(sclk), .SERIAL_IN_I(sdio), .SERIAL_OUT_O(s_out),
        .SERIAL_OUT_OE_O(s_oe), .EXTENDED_CONTROL_MODE_O(ext_mode),
        .DUAL_EDGE_SELECT_O(dual), .TEST_PATTERN_SELECT_O(tpat),
        .OUTPUT_CLOCK_PHASE_SELECT_O(phase), .OUTPUT_SWING_SELECT_O(swing),
        .TWOS_COMPLEMENT_SELECT_O(twos));

    // counted comparison with a mismatch line
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // test word per address, last nibble the inverse of the first
    function automatic logic [15:0] pat(input logic [3:0] a);
        return {a, ~a, a ^ 4'h9, ~a};
    endfunction

    // config outputs packed, twos complement in the low bit
    function automatic logic [15:0] cfg();
        return {11'h000, phase, swing, tpat, dual, twos};
    endfunction

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // mode pin enters extended mode; defaults beforehand
    task automatic t_mode();
        check("mode off", 16'h0000, {15'h0000, ext_mode});
        check("cfg default", 16'h0000, cfg());
        mode_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("mode on", 16'h0001, {15'h0000, ext_mode});
        $display("test mode done");
    endtask

    // every address written then read back; unmapped reads zero
    task automatic t_regs();
        logic [15:0] exp;
        for (int a = 0; a < 16; a++) begin
            host.frame(1'b0, 4'(a), pat(4'(a)), 24, 0);
            check("oe in write", 16'h0000, {15'h0000, host.early_oe});
        end
        for (int a = 0; a < 16; a++) begin
            exp = `SCRP_IMPL_MASK >> a & 16'h0001 ? pat(4'(a)) : 16'h0000;
            host.frame(1'b1, 4'(a), 16'h0000, 24, 0);
            check("read data", exp, host.rd);
            check("oe in command", 16'h0000, {15'h0000, host.early_oe});
            check("oe after frame", 16'h0000, {15'h0000, s_oe});
        end
        $display("test regs done");
    endtask

    // each main configuration bit reaches its own output
    task automatic t_config();
        int pos[5] = '{4, 7, 12, 13, 14};
        for (int k = 0; k < 5; k++) begin
            host.frame(1'b0, 4'h0, 16'h0001 << pos[k], 24, 0);
            check("cfg bit", 16'h0001 << k, cfg());
        end
        host.frame(1'b0, 4'h0, 16'h0000, 24, 0);
        check("cfg clear", 16'h0000, cfg());
        $display("test config done");
    endtask

    // select released after 23 clocks abandons the access
    task automatic t_abort();
        host.frame(1'b0, 4'h1, ~pat(4'h1), 23, 0);
        host.frame(1'b1, 4'h1, 16'h0000, 23, 0);
        check("oe after abort", 16'h0000, {15'h0000, s_oe});
        host.frame(1'b1, 4'h1, 16'h0000, 24, 0);
        check("kept after abort", pat(4'h1), host.rd);
        $display("test abort done");
    endtask

    // overlong frames with a stopped clock in mid-frame
    task automatic t_long();
        host.frame(1'b0, 4'h2, 16'h8001, 28, 6);
        host.frame(1'b1, 4'h2, 16'h0000, 28, 6);
        check("long read", 16'h8001, host.rd);
        check("last bit held", 16'h0000, {15'h0000, host.tail_bad});
        check("oe after long", 16'h0000, {15'h0000, s_oe});
        $display("test long done");
    endtask

    // mode pin high clears registers and ignores frames
    task automatic t_clear();
        host.frame(1'b0, 4'h0, 16'h7090, 24, 0);
        check("cfg set", 16'h001f, cfg());
        mode_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        check("cfg held", 16'h0000, cfg());
        check("mode dropped", 16'h0000, {15'h0000, ext_mode});
        host.frame(1'b0, 4'h3, 16'hffff, 24, 0);
        mode_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        host.frame(1'b1, 4'h0, 16'h0000, 24, 0);
        check("reg0 cleared", 16'h0000, host.rd);
        host.frame(1'b1, 4'h3, 16'h0000, 24, 0);
        check("reg3 cleared", 16'h0000, host.rd);
        $display("test clear done");
    endtask

    // guard against a hung run
    initial begin
        repeat (90000) @(negedge clk_sys);
        err_total++;
        $display("[FAIL] run time expected under limit seen over");
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_mode();
        t_regs();
        t_config();
        t_abort();
        t_long();
        t_clear();
        wrap_up();
    end
endmodule
